// *** pcs_top.sv ***
// Functional notes
// - addresses span an 8K-word by 13-bit program ROM.
// - pages are 1024 words; low ten counter bits pick the word.
// - any reset clears the whole program counter to zero.
// - jump loads its operand into the low ten counter bits.
// - call loads low ten bits and pushes the following instruction address.
// - every return form reloads the counter from the stack top.
// - adding the accumulator carries into counter bits eight and nine.
// - moving the accumulator replaces the low eight counter bits; page select loads bits twelve to ten.
// - other counter writes, bit clears included, keep bits eight and nine.
// - jump, call or counter write loads bits twelve to ten from page select.
// - instructions not writing the counter take one instruction cycle.
// - counter-writing instructions take one or two cycles per option bit.
// - the return stack holds up to eight nested addresses.
// - returns ignore page select and resume on the calling page.
`timescale 1ns/1ns
`default_nettype none
module pcs_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic div4_sel,
  input wire logic branch_cycle_option,
  input wire pcs_pkg::pcs_op_e op,
  input wire logic [9:0] operand_k,
  input wire logic [7:0] acc,
  input wire logic [7:0] write_data,
  input wire logic [2:0] page_select_bits,
  output logic [12:0] rom_addr,
  output logic [7:0] pc_low,
  output logic inst_en,
  output logic bubble
);
  import pcs_pkg::*;

  pcs_stack_if st ();
  logic [12:0] program_counter_reg;
  logic [12:0] pc_next;
  logic bubble_reg;
  logic bubble_next;
  logic exec;
  logic is_ret;
  logic is_call;
  logic writes_pc;
  logic [9:0] add_low;
  logic [12:0] jump_target;
  logic [12:0] add_target;
  logic [12:0] write_target;
  logic [12:0] seq_target;
  logic [2:0] gap_reg;
  logic [2:0] gap_next;
  logic [2:0] bub_run_reg;
  logic [2:0] bub_run_next;

  // joins a three-bit page above a ten-bit word; jump and add pass the status bits as the page
  function automatic logic [12:0] page_join(input logic [2:0] page, input logic [9:0] offset);
    page_join = {page, offset};
  endfunction

  // the three return forms look alike to the counter and the stack
  function automatic logic op_is_return(input pcs_op_e o);
    op_is_return = (o == PCS_OP_RET) || (o == PCS_OP_RETURN_WITH_LITERAL) || (o == PCS_OP_RETURN_FROM_INTERRUPT);
  endfunction

  pcs_cycle_gen u_cycle (
    .mclk(mclk),
    .rst(rst),
    .div4_sel(div4_sel),
    .inst_en(inst_en)
  );

  pcs_stack #(.DEPTH(PCS_STACK_DEPTH)) u_stack (
    .mclk(mclk),
    .rst(rst),
    .st(st)
  );

  // a dummy cycle after a taken counter write swallows whatever the decoder presents
  assign exec = inst_en && !bubble_reg;
  assign is_ret = op_is_return(op);
  assign is_call = (op == PCS_OP_CALL);
  assign writes_pc = (op != PCS_OP_NEXT);

  // 13-bit address: page from status bits, word within page from the low ten bits
  assign jump_target = page_join(page_select_bits, operand_k);
  assign add_low = program_counter_reg[9:0] + {2'h0, acc};
  assign add_target = page_join(page_select_bits, add_low);
  assign write_target = {page_select_bits, program_counter_reg[9:PCS_MOV_LSB], write_data};
  assign seq_target = program_counter_reg + 13'h0001;

  assign st.push = exec && is_call;
  assign st.pop = exec && is_ret;
  assign st.wr_data = seq_target;

  always_comb begin
    pc_next = program_counter_reg;
    if (exec) begin
      case (op)
        PCS_OP_NEXT: pc_next = seq_target;
        PCS_OP_JUMP: pc_next = jump_target;
        PCS_OP_CALL: pc_next = jump_target;
        PCS_OP_RET: pc_next = st.top_data;
        PCS_OP_RETURN_WITH_LITERAL: pc_next = st.top_data;
        PCS_OP_RETURN_FROM_INTERRUPT: pc_next = st.top_data;
        PCS_OP_ADD: pc_next = add_target;
        PCS_OP_WRITE: pc_next = write_target;
        default: pc_next = program_counter_reg;
      endcase
    end
  end

  // option set: one extra cycle while the fetch at the new address refills
  assign bubble_next = inst_en ? (exec && writes_pc && branch_cycle_option) : bubble_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      program_counter_reg <= PCS_PC_RESET;
      bubble_reg <= 1'b0;
    end else begin
      program_counter_reg <= pc_next;
      bubble_reg <= bubble_next;
    end
  end

  assign rom_addr = program_counter_reg;
  assign pc_low = program_counter_reg[7:0];
  assign bubble = bubble_reg;

  // checker-only counters: clocks since the last slot, and length of the current bubble
  assign gap_next = inst_en ? 3'h0 : (gap_reg == 3'h7 ? gap_reg : gap_reg + 3'h1);
  assign bub_run_next = !bubble_reg ? 3'h0 : (bub_run_reg == 3'h7 ? bub_run_reg : bub_run_reg + 3'h1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_reg <= 3'h0;
      bub_run_reg <= 3'h0;
    end else begin
      gap_reg <= gap_next;
      bub_run_reg <= bub_run_next;
    end
  end

  chk_reset_clear: assert property (@(posedge mclk)
    rst |=> program_counter_reg == 13'h0000)
    else $error("counter not cleared by reset");

  chk_seq_advance: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_NEXT) |=> program_counter_reg == $past(program_counter_reg) + 13'h0001)
    else $error("counter did not advance by one");

  chk_jump_load: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_JUMP) |=> program_counter_reg == {$past(page_select_bits), $past(operand_k)})
    else $error("jump target wrong");

  property p_call_push;
    @(posedge mclk) disable iff (rst)
      (exec && is_call) |=> ##1 st.top_data == $past(program_counter_reg, 2) + 13'h0001;
  endproperty
  chk_call_push: assert property (p_call_push)
    else $error("call did not push the following address");

  chk_return_pop: assert property (@(posedge mclk) disable iff (rst)
    (exec && is_ret) |=> program_counter_reg == $past(st.top_data))
    else $error("return did not reload from stack top");

  chk_return_page: assert property (@(posedge mclk) disable iff (rst)
    (exec && is_ret && page_select_bits != st.top_data[12:10])
      |=> program_counter_reg[12:10] != $past(page_select_bits))
    else $error("return took its page from page select");

  chk_add_carry: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_ADD)
      |=> program_counter_reg == {$past(page_select_bits), $past(program_counter_reg[9:0]) + {2'h0, $past(acc)}})
    else $error("relative add wrong");

  chk_write_keep: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_WRITE)
      |=> program_counter_reg[9:8] == $past(program_counter_reg[9:8]) && pc_low == $past(write_data)
        && program_counter_reg[12:10] == $past(page_select_bits))
    else $error("counter write disturbed bits eight and nine");

  chk_cycle_spacing: assert property (@(posedge mclk) disable iff (rst)
    inst_en |=> !inst_en ##[1:3] inst_en)
    else $error("instruction cycle not two or four clocks");

  chk_branch_bubble: assert property (@(posedge mclk) disable iff (rst)
    (exec && writes_pc && branch_cycle_option) |=> bubble ##[1:4] (inst_en && bubble) ##1 !bubble)
    else $error("branch bubble not exactly one cycle");

  chk_no_bubble: assert property (@(posedge mclk) disable iff (rst)
    (inst_en && !(exec && writes_pc && branch_cycle_option)) |=> !bubble)
    else $error("unexpected bubble");

  chk_bubble_hold: assert property (@(posedge mclk) disable iff (rst)
    (inst_en && bubble) |=> $stable(program_counter_reg))
    else $error("counter moved in bubble cycle");

  // counter and stack move only on a taken slot
  chk_idle_hold: assert property (@(posedge mclk) disable iff (rst)
    !exec |=> $stable(program_counter_reg))
    else $error("counter moved outside a taken slot");

  chk_idle_stack: assert property (@(posedge mclk) disable iff (rst)
    (!exec || (!is_call && !is_ret)) |=> $stable(st.ptr))
    else $error("stack pointer moved without call or return");

  chk_call_target: assert property (@(posedge mclk) disable iff (rst)
    (exec && is_call) |=> program_counter_reg == {$past(page_select_bits), $past(operand_k)})
    else $error("call target wrong");

  // stack pointer bookkeeping
  chk_call_ptr: assert property (@(posedge mclk) disable iff (rst)
    (exec && is_call) |=> st.ptr == $past(st.ptr) + 3'h1)
    else $error("call did not advance the stack pointer");

  chk_ret_ptr: assert property (@(posedge mclk) disable iff (rst)
    (exec && is_ret) |=> st.ptr == $past(st.ptr) - 3'h1)
    else $error("return did not step the stack pointer back");

  chk_return_with_literal_pop: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_RETURN_WITH_LITERAL) |=> program_counter_reg == $past(st.top_data))
    else $error("literal return did not reload from stack top");

  chk_return_from_interrupt_pop: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_RETURN_FROM_INTERRUPT) |=> program_counter_reg == $past(st.top_data))
    else $error("interrupt return did not reload from stack top");

  chk_ret_top: assert property (@(posedge mclk) disable iff (rst)
    (exec && is_ret) |=> program_counter_reg[12:10] == $past(st.top_data[12:10]))
    else $error("return did not resume on the calling page");

  chk_write_nine: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_WRITE) |=> program_counter_reg[9:8] == $past(program_counter_reg[9:8]))
    else $error("counter write changed bits eight and nine");

  chk_write_low: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_WRITE) |=> pc_low == $past(write_data))
    else $error("counter write did not replace the low byte");

  chk_write_page: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_WRITE) |=> program_counter_reg[12:10] == $past(page_select_bits))
    else $error("counter write did not take the page bits");

  chk_add_page: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_ADD) |=> program_counter_reg[12:10] == $past(page_select_bits))
    else $error("relative add did not take the page bits");

  chk_add_word: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_ADD) |=> program_counter_reg[9:0] == $past(program_counter_reg[9:0]) + {2'h0, $past(acc)})
    else $error("relative add lost its carry");

  chk_seq_wrap: assert property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_NEXT && program_counter_reg == 13'h1FFF) |=> program_counter_reg == 13'h0000)
    else $error("counter did not wrap at the top of the address space");

  // reset and slot timing
  chk_reset_state: assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> program_counter_reg == 13'h0000 && !bubble && !inst_en)
    else $error("state not clean on the first edge after reset");

  chk_ptr_cleared: assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> st.ptr == 3'h0)
    else $error("stack pointer not cleared by reset");

  chk_gap_min: assert property (@(posedge mclk) disable iff (rst)
    inst_en |-> gap_reg != 3'h0)
    else $error("two slots on adjacent clocks");

  chk_gap_max: assert property (@(posedge mclk) disable iff (rst)
    inst_en |-> gap_reg <= 3'h3)
    else $error("slot spacing longer than four clocks");

  // a bubble lasts one instruction cycle, so never more than four clocks
  chk_bubble_len: assert property (@(posedge mclk) disable iff (rst)
    bubble |-> bub_run_reg <= 3'h3)
    else $error("bubble stood too long");

  chk_bubble_edge: assert property (@(posedge mclk) disable iff (rst)
    !inst_en |=> $stable(bubble))
    else $error("bubble changed between slots");

  chk_bubble_stack: assert property (@(posedge mclk) disable iff (rst)
    (inst_en && bubble) |=> $stable(st.ptr))
    else $error("stack moved in bubble cycle");

  chk_option_off: assert property (@(posedge mclk) disable iff (rst)
    (exec && writes_pc && !branch_cycle_option) |=> !bubble)
    else $error("bubble inserted with the option clear");

  cov_call_ret: cover property (@(posedge mclk) disable iff (rst)
    (exec && is_call) ##[1:20] (exec && is_ret));
  cov_bubble: cover property (@(posedge mclk) disable iff (rst)
    (inst_en && bubble));
  cov_add_carry: cover property (@(posedge mclk) disable iff (rst)
    (exec && op == PCS_OP_ADD && add_low[9:8] != program_counter_reg[9:8]));
  cov_stack_wrap: cover property (@(posedge mclk) disable iff (rst)
    (st.push && st.ptr == 3'h7));
  cov_div4_bubble: cover property (@(posedge mclk) disable iff (rst)
    (inst_en && bubble && div4_sel));
endmodule
`default_nettype wire

// *** pcs_pkg.sv ***
package pcs_pkg;
  localparam int PCS_ADDR_W = 13;
  localparam int PCS_PAGE_W = 10;
  localparam int PCS_PS_W = 3;
  localparam int PCS_STACK_DEPTH = 8;
  localparam int PCS_PTR_W = 3;
  localparam logic [12:0] PCS_PC_RESET = 13'h0000;
  localparam logic [2:0] PCS_PTR_RESET = 3'h0;
  localparam logic [1:0] PCS_LAST_TICK_DIV2 = 2'h1;
  localparam logic [1:0] PCS_LAST_TICK_DIV4 = 2'h3;
  localparam int PCS_MOV_LSB = 8;
  typedef enum logic [2:0] {
    PCS_OP_NEXT,
    PCS_OP_JUMP,
    PCS_OP_CALL,
    PCS_OP_RET,
    PCS_OP_RETURN_WITH_LITERAL,
    PCS_OP_RETURN_FROM_INTERRUPT,
    PCS_OP_ADD,
    PCS_OP_WRITE
  } pcs_op_e;
endpackage

// *** pcs_stack_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface pcs_stack_if;
  logic push;
  logic pop;
  logic [12:0] wr_data;
  logic [12:0] top_data;
  logic [2:0] ptr;
  modport core (output push, output pop, output wr_data, input top_data, input ptr);
  modport mem (input push, input pop, input wr_data, output top_data, output ptr);
endinterface
`default_nettype wire

// *** pcs_stack.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcs_stack #(
  parameter int DEPTH = pcs_pkg::PCS_STACK_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  pcs_stack_if.mem st
);
  import pcs_pkg::*;
  logic [12:0] mem_q [DEPTH];
  logic [2:0] ptr_reg;
  logic [2:0] ptr_next;
  logic [2:0] rd_idx;
  logic [12:0] top_reg;

  // pointer simply wraps: a ninth push overwrites the oldest entry, no error flag
  assign ptr_next = st.push ? ptr_reg + 3'h1 : (st.pop ? ptr_reg - 3'h1 : ptr_reg);
  assign rd_idx = ptr_reg - 3'h1;
  assign st.ptr = ptr_reg;
  assign st.top_data = top_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr_reg <= PCS_PTR_RESET;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // registered read lags one clock; an instruction cycle is never shorter than two
  always_ff @(posedge mclk) begin
    if (st.push) begin
      mem_q[ptr_reg] <= st.wr_data;
    end
    top_reg <= mem_q[rd_idx];
  end

  chk_ptr_wrap: assert property (@(posedge mclk) disable iff (rst)
    (st.push && ptr_reg == 3'h7) |=> ptr_reg == 3'h0)
    else $error("stack pointer did not wrap on push");
  chk_pop_wrap: assert property (@(posedge mclk) disable iff (rst)
    (st.pop && !st.push && ptr_reg == 3'h0) |=> ptr_reg == 3'h7)
    else $error("stack pointer did not wrap on pop");
endmodule
`default_nettype wire

// *** pcs_cycle_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcs_cycle_gen (
  input wire logic mclk,
  input wire logic rst,
  input wire logic div4_sel,
  output logic inst_en
);
  import pcs_pkg::*;
  logic [1:0] cnt_reg;
  logic [1:0] last_tick;

  assign last_tick = div4_sel ? PCS_LAST_TICK_DIV4 : PCS_LAST_TICK_DIV2;
  assign inst_en = (cnt_reg >= last_tick);

  always_ff @(posedge mclk) begin
    if (rst || inst_en) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** pcs_rom_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcs_rom_model (
  input wire logic [12:0] rom_addr,
  output logic [12:0] rom_word
);
  // every one of the 8K addresses holds a 13-bit word, so no address aliases
  assign rom_word = rom_addr ^ 13'h1FFF;
endmodule
`default_nettype wire

// *** program_counter_and_stack_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module program_counter_and_stack_test;
  import pcs_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic div4_sel = 1'b0;
  logic branch_cycle_option = 1'b0;
  pcs_op_e op = PCS_OP_NEXT;
  logic [9:0] operand_k = 10'h000;
  logic [7:0] acc = 8'h00;
  logic [7:0] write_data = 8'h00;
  logic [2:0] page_select_bits = 3'h0;
  logic [12:0] rom_addr;
  logic [7:0] pc_low;
  logic inst_en;
  logic bubble;
  logic [12:0] rom_word;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  pcs_top pcs_top_i (.mclk(mclk), .rst(rst), .div4_sel(div4_sel), .branch_cycle_option(branch_cycle_option),
    .op(op), .operand_k(operand_k), .acc(acc), .write_data(write_data), .page_select_bits(page_select_bits),
    .rom_addr(rom_addr), .pc_low(pc_low), .inst_en(inst_en), .bubble(bubble));
  pcs_rom_model pcs_rom_model_i (.rom_addr(rom_addr), .rom_word(rom_word));
  always #4 mclk = ~mclk;
  // whole run needs a few hundred cycles; the ceiling leaves wide margin
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [12:0] seen, input logic [12:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task do_reset;
    @(negedge mclk);
    rst = 1'b1;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
  endtask
  // inst_en is only a one-cycle pulse, so wait at falling edges with a bound
  task wait_slot;
    int n;
    n = 0;
    @(negedge mclk);
    while (!(inst_en === 1'b1 && bubble === 1'b0) && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 50) check(13'h0001, 13'h0000);
  endtask
  task issue(input pcs_op_e o, input logic [9:0] k, input logic [7:0] a, input logic [2:0] ps);
    wait_slot;
    op = o;
    operand_k = k;
    acc = a;
    write_data = a;
    page_select_bits = ps;
    @(negedge mclk);
    op = PCS_OP_NEXT;
  endtask
  task test_spacing(input logic d4);
    int n;
    div4_sel = d4;
    do_reset;
    check(rom_addr, 13'h0000);
    wait_slot;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (inst_en !== 1'b1 && n < 10);
    check(13'(n), d4 ? 13'h0004 : 13'h0002);
    repeat (3) issue(PCS_OP_NEXT, 10'h000, 8'h00, 3'h7);
    // every slot since reset stepped: two while timing, three issued
    check(rom_addr, 13'h0005);
    div4_sel = 1'b0;
    $display("test spacing done");
  endtask
  task test_jump_add_write;
    do_reset;
    issue(PCS_OP_JUMP, 10'h3FF, 8'h00, 3'h7);
    check(rom_addr, 13'h1FFF);
    check(rom_word, 13'h0000);
    issue(PCS_OP_NEXT, 10'h000, 8'h00, 3'h2);
    check(rom_addr, 13'h0000);
    issue(PCS_OP_JUMP, 10'h0FE, 8'h00, 3'h1);
    issue(PCS_OP_ADD, 10'h000, 8'h05, 3'h1);
    check(rom_addr, 13'h0503);
    issue(PCS_OP_JUMP, 10'h3FF, 8'h00, 3'h6);
    issue(PCS_OP_ADD, 10'h000, 8'h02, 3'h6);
    check(rom_addr, 13'h1801);
    issue(PCS_OP_JUMP, 10'h2AB, 8'h00, 3'h3);
    issue(PCS_OP_WRITE, 10'h000, 8'h5C, 3'h4);
    check(rom_addr, 13'h125C);
    check({5'h00, pc_low}, 13'h005C);
    $display("test jump add write done");
  endtask
  task test_call_ret;
    pcs_op_e rets [3];
    logic [12:0] ra;
    rets = '{PCS_OP_RET, PCS_OP_RETURN_WITH_LITERAL, PCS_OP_RETURN_FROM_INTERRUPT};
    do_reset;
    issue(PCS_OP_JUMP, 10'h123, 8'h00, 3'h2);
    ra = 13'h0924;
    for (int i = 0; i < 3; i++) begin
      issue(PCS_OP_CALL, 10'h050 + 10'(i), 8'h00, 3'h5);
      check(rom_addr, 13'h1450 + 13'(i));
      issue(rets[i], 10'h000, 8'h00, 3'h1);
      check(rom_addr, ra);
      ra = ra + 13'h0001;
    end
    $display("test call return done");
  endtask
  task test_stack_wrap;
    do_reset;
    // nine calls: the ninth overwrites the oldest return address
    for (int i = 0; i < 9; i++) issue(PCS_OP_CALL, 10'h100 + 10'(i), 8'h00, 3'h0);
    for (int j = 0; j < 8; j++) begin
      issue(PCS_OP_RET, 10'h000, 8'h00, 3'h6);
      check(rom_addr, 13'h0108 - 13'(j));
    end
    issue(PCS_OP_RET, 10'h000, 8'h00, 3'h6);
    check(rom_addr, 13'h0108);
    $display("test stack wrap done");
  endtask
  task test_bubble(input logic d4);
    div4_sel = d4;
    branch_cycle_option = 1'b1;
    do_reset;
    issue(PCS_OP_JUMP, 10'h010, 8'h00, 3'h0);
    check({12'h000, bubble}, 13'h0001);
    issue(PCS_OP_NEXT, 10'h000, 8'h00, 3'h0);
    check(rom_addr, 13'h0011);
    branch_cycle_option = 1'b0;
    issue(PCS_OP_JUMP, 10'h020, 8'h00, 3'h0);
    check({12'h000, bubble}, 13'h0000);
    div4_sel = 1'b0;
    $display("test bubble done");
  endtask
  initial begin
    test_spacing(1'b0);
    test_spacing(1'b1);
    test_jump_add_write;
    test_call_ret;
    test_stack_wrap;
    test_bubble(1'b0);
    test_bubble(1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
